/* core/irq_prio_pkg.sv */
// constants for the interrupt priority and vector status block
// assumes one clock domain; sources, flags and enables come from local logic
//
// Contract
// [R01] code 111 is level 7, 001 level 1
// [R02] code 000 disables the source entirely
// [R03] unimplemented bits read zero, ignore writes
// [R04] reset sets every source field to 100
// [R05] serial3 transmit/receive/fault fields at 14/10/6
// [R06] serial4 fault 14-12; transmit 6-4, receive 2-0
// [R07] display field 2-0; debug field 6-4
// [R08] bit 15 flags request masked by cpu
// [R09] select set: vector shows highest pending
// [R10] select clear: vector shows last acknowledged
// [R11] bits 11-8 report new cpu level
// [R12] bits 6-0 report vector 0 to 118
// [R13] status fields read-only, reset zero, hardware-updated
// [R14] software sets nesting disable before enabling
// [R15] software writes each source priority field
// [R16] software clears flag before setting enable
// [R17] request needs enable, flag, nonzero priority
// [R18] handler clears flag or request repeats
// [R19] trap levels 8-15 are never masked
// [R20] equal levels: lowest vector number wins
package irq_prio_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam int         ADDR_W       = 3;
    localparam int         DATA_W       = 16;
    localparam logic [2:0] OFS_SERIAL3  = 3'h0;
    localparam logic [2:0] OFS_S4_FAULT = 3'h1;
    localparam logic [2:0] OFS_S4_TXRX  = 3'h2;
    localparam logic [2:0] OFS_DISPLAY  = 3'h3;
    localparam logic [2:0] OFS_DEBUG    = 3'h4;
    localparam logic [2:0] OFS_TEST     = 3'h5;

    // -------------------------------------------------------------
    // sources, in ascending vector order
    // -------------------------------------------------------------
    localparam int NUM_SRC    = 8;
    localparam int LVL_W      = 3;
    localparam int IDX_W      = 3;
    localparam int SRC_S3_ERR = 0;
    localparam int SRC_S3_RX  = 1;
    localparam int SRC_S3_TX  = 2;
    localparam int SRC_S4_ERR = 3;
    localparam int SRC_S4_RX  = 4;
    localparam int SRC_S4_TX  = 5;
    localparam int SRC_DISP   = 6;
    localparam int SRC_DBG    = 7;

    localparam logic [6:0] VEC_S3_ERR = 7'h41;
    localparam logic [6:0] VEC_S3_RX  = 7'h42;
    localparam logic [6:0] VEC_S3_TX  = 7'h43;
    localparam logic [6:0] VEC_S4_ERR = 7'h45;
    localparam logic [6:0] VEC_S4_RX  = 7'h46;
    localparam logic [6:0] VEC_S4_TX  = 7'h47;
    localparam logic [6:0] VEC_DISP   = 7'h64;
    localparam logic [6:0] VEC_DBG    = 7'h75;
    localparam logic [6:0] VEC_MAX    = 7'h76;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int POS_S3_TX  = 12;
    localparam int POS_S3_RX  = 8;
    localparam int POS_S3_ERR = 4;
    localparam int POS_S4_ERR = 12;
    localparam int POS_S4_TX  = 4;
    localparam int POS_S4_RX  = 0;
    localparam int POS_DISP   = 0;
    localparam int POS_DBG    = 4;
    localparam int POS_UNACK  = 15;
    localparam int POS_VSEL   = 13;
    localparam int POS_LEVEL  = 8;
    localparam int POS_VEC    = 0;

    localparam logic [2:0]  LEVEL_RESET = 3'h4;
    localparam logic [2:0]  LEVEL_OFF   = 3'h0;
    localparam logic [15:0] MASK_SERIAL3  = 16'h7770;
    localparam logic [15:0] MASK_S4_FAULT = 16'h7000;
    localparam logic [15:0] MASK_S4_TXRX  = 16'h0077;
    localparam logic [15:0] MASK_DISPLAY  = 16'h0007;
    localparam logic [15:0] MASK_DEBUG    = 16'h0070;
    localparam logic [15:0] MASK_TEST     = 16'haf7f;

endpackage : irq_prio_pkg

/* core/irq_prio_resolver.sv */
// highest-level pending source picker
// assumes levels are packed three bits per source, index 0 lowest
`timescale 1ns/10ps
`default_nettype none
module irq_prio_resolver
(
    // sources
    input  wire logic [7:0]  pending_in,
    input  wire logic [23:0] levels_in,
    // result
    output logic             found_out,
    output logic [2:0]       level_out,
    output logic [2:0]       index_out
);

    // -------------------------------------------------------------
    // scan
    // -------------------------------------------------------------
    always_comb
    begin
        found_out = 1'b0;
        level_out = irq_prio_pkg::LEVEL_OFF;
        index_out = 3'h0;
        for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
        begin
            // strict compare keeps the lower index on a tie
            if (pending_in[i] && (!found_out ||
                levels_in[i*3 +: 3] > level_out)) // [R20]
            begin
                found_out = 1'b1;
                level_out = levels_in[i*3 +: 3]; // [R01]
                index_out = 3'(i);
            end
        end
    end

endmodule : irq_prio_resolver
`default_nettype wire

/* core/irq_prio_ctrl.sv */
// priority fields, request logic and test/status register
// assumes flags, enables, traps and cpu acknowledge share clk_in
`timescale 1ns/10ps
`default_nettype none
module irq_prio_ctrl
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        ce_in,
    // register port
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    // sources
    input  wire logic [7:0]  flag_in,
    input  wire logic [7:0]  enable_in,
    input  wire logic        trap_req_in,
    input  wire logic [3:0]  trap_level_in,
    input  wire logic [6:0]  trap_vector_in,
    // cpu
    input  wire logic [3:0]  cpu_level_in,
    input  wire logic        ack_in,
    output logic             irq_out,
    output logic [3:0]       irq_level_out,
    output logic [6:0]       irq_vector_out
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [6:0] vector_of(input logic [2:0] idx);
        logic [6:0] v;
        v = irq_prio_pkg::VEC_S3_ERR;
        case (idx)
            3'h1: v = irq_prio_pkg::VEC_S3_RX;
            3'h2: v = irq_prio_pkg::VEC_S3_TX;
            3'h3: v = irq_prio_pkg::VEC_S4_ERR;
            3'h4: v = irq_prio_pkg::VEC_S4_RX;
            3'h5: v = irq_prio_pkg::VEC_S4_TX;
            3'h6: v = irq_prio_pkg::VEC_DISP;
            3'h7: v = irq_prio_pkg::VEC_DBG;
            default: v = irq_prio_pkg::VEC_S3_ERR;
        endcase
        return v;
    endfunction : vector_of

    function automatic logic [15:0] place(input logic [2:0] v,
                                          input int         pos);
        return 16'({13'h0, v} << pos);
    endfunction : place

    function automatic logic [15:0] mask_of(input logic [2:0] a);
        logic [15:0] m;
        m = 16'h0000;
        if (a == irq_prio_pkg::OFS_SERIAL3)
            m = irq_prio_pkg::MASK_SERIAL3;
        else if (a == irq_prio_pkg::OFS_S4_FAULT)
            m = irq_prio_pkg::MASK_S4_FAULT;
        else if (a == irq_prio_pkg::OFS_S4_TXRX)
            m = irq_prio_pkg::MASK_S4_TXRX;
        else if (a == irq_prio_pkg::OFS_DISPLAY)
            m = irq_prio_pkg::MASK_DISPLAY;
        else if (a == irq_prio_pkg::OFS_DEBUG)
            m = irq_prio_pkg::MASK_DEBUG;
        else if (a == irq_prio_pkg::OFS_TEST)
            m = irq_prio_pkg::MASK_TEST;
        return m;
    endfunction : mask_of

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [2:0]  level_q [8];
    logic [2:0]  level_d [8];
    logic        vsel_q;
    logic        vsel_d;
    logic        unack_q;
    logic        unack_d;
    logic [3:0]  new_level_q;
    logic [3:0]  new_level_d;
    logic [6:0]  vec_last_q;
    logic [6:0]  vec_last_d;
    logic [6:0]  vec_live_q;
    logic [6:0]  vec_live_d;
    logic        req_q;
    logic        req_d;
    logic [3:0]  lvl_q;
    logic [3:0]  lvl_d;
    logic [6:0]  vec_q;
    logic [6:0]  vec_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    logic [7:0]  pending;
    logic [23:0] levels_flat;
    logic        found;
    logic [2:0]  best_level;
    logic [2:0]  best_index;
    logic [3:0]  sel_level;
    logic [6:0]  sel_vec;
    logic        any_pending;
    logic        sel_request;

    // -------------------------------------------------------------
    // pending sources
    // -------------------------------------------------------------
    for (genvar g = 0; g < irq_prio_pkg::NUM_SRC; g++)
    begin : g_src
        assign pending[g] = flag_in[g] & enable_in[g] &
                            (level_q[g] != irq_prio_pkg::LEVEL_OFF); // [R17] [R02]
        assign levels_flat[g*3 +: 3] = level_q[g];
    end

    irq_prio_resolver irq_prio_resolver_inst
    (
        .pending_in (pending),
        .levels_in  (levels_flat),
        .found_out  (found),
        .level_out  (best_level),
        .index_out  (best_index)
    );

    // -------------------------------------------------------------
    // selection against cpu level
    // -------------------------------------------------------------
    always_comb
    begin
        any_pending = trap_req_in | found;
        if (trap_req_in)
        begin
            sel_level   = trap_level_in;
            sel_vec     = trap_vector_in;
            sel_request = 1'b1; // [R19]
        end
        else
        begin
            sel_level   = {1'b0, best_level};
            sel_vec     = vector_of(best_index);
            sel_request = found && ({1'b0, best_level} > cpu_level_in);
        end
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
            level_d[i] = level_q[i];
        vsel_d     = vsel_q;
        rdata_d    = 16'h0000;
        req_d      = sel_request;
        lvl_d      = sel_level;
        vec_d      = sel_vec;
        unack_d    = any_pending && !sel_request; // [R08]
        vec_live_d = any_pending ? sel_vec : 7'h00; // [R09]
        new_level_d = new_level_q;
        vec_last_d = vec_last_q;
        if (ack_in && req_q)
        begin
            new_level_d = lvl_q; // [R11]
            vec_last_d = vec_q; // [R10]
        end
        if (wr_in)
        begin
            // bits outside the fields are dropped
            if (addr_in == irq_prio_pkg::OFS_SERIAL3) // [R05]
            begin
                level_d[irq_prio_pkg::SRC_S3_TX] =
                    wdata_in[irq_prio_pkg::POS_S3_TX +: 3];
                level_d[irq_prio_pkg::SRC_S3_RX] =
                    wdata_in[irq_prio_pkg::POS_S3_RX +: 3];
                level_d[irq_prio_pkg::SRC_S3_ERR] =
                    wdata_in[irq_prio_pkg::POS_S3_ERR +: 3];
            end
            else if (addr_in == irq_prio_pkg::OFS_S4_FAULT) // [R06]
                level_d[irq_prio_pkg::SRC_S4_ERR] =
                    wdata_in[irq_prio_pkg::POS_S4_ERR +: 3];
            else if (addr_in == irq_prio_pkg::OFS_S4_TXRX) // [R06]
            begin
                level_d[irq_prio_pkg::SRC_S4_TX] =
                    wdata_in[irq_prio_pkg::POS_S4_TX +: 3];
                level_d[irq_prio_pkg::SRC_S4_RX] =
                    wdata_in[irq_prio_pkg::POS_S4_RX +: 3];
            end
            else if (addr_in == irq_prio_pkg::OFS_DISPLAY) // [R07]
                level_d[irq_prio_pkg::SRC_DISP] =
                    wdata_in[irq_prio_pkg::POS_DISP +: 3];
            else if (addr_in == irq_prio_pkg::OFS_DEBUG) // [R07]
                level_d[irq_prio_pkg::SRC_DBG] =
                    wdata_in[irq_prio_pkg::POS_DBG +: 3];
            else if (addr_in == irq_prio_pkg::OFS_TEST)
                vsel_d = wdata_in[irq_prio_pkg::POS_VSEL]; // [R13]
        end
        if (rd_in)
        begin
            if (addr_in == irq_prio_pkg::OFS_SERIAL3)
                rdata_d =
                    place(level_q[irq_prio_pkg::SRC_S3_TX],
                          irq_prio_pkg::POS_S3_TX) |
                    place(level_q[irq_prio_pkg::SRC_S3_RX],
                          irq_prio_pkg::POS_S3_RX) |
                    place(level_q[irq_prio_pkg::SRC_S3_ERR],
                          irq_prio_pkg::POS_S3_ERR);
            else if (addr_in == irq_prio_pkg::OFS_S4_FAULT)
                rdata_d = place(level_q[irq_prio_pkg::SRC_S4_ERR],
                                irq_prio_pkg::POS_S4_ERR);
            else if (addr_in == irq_prio_pkg::OFS_S4_TXRX)
                rdata_d =
                    place(level_q[irq_prio_pkg::SRC_S4_TX],
                          irq_prio_pkg::POS_S4_TX) |
                    place(level_q[irq_prio_pkg::SRC_S4_RX],
                          irq_prio_pkg::POS_S4_RX);
            else if (addr_in == irq_prio_pkg::OFS_DISPLAY)
                rdata_d = place(level_q[irq_prio_pkg::SRC_DISP],
                                irq_prio_pkg::POS_DISP);
            else if (addr_in == irq_prio_pkg::OFS_DEBUG)
                rdata_d = place(level_q[irq_prio_pkg::SRC_DBG],
                                irq_prio_pkg::POS_DBG);
            else if (addr_in == irq_prio_pkg::OFS_TEST)
            begin
                rdata_d[irq_prio_pkg::POS_UNACK] = unack_q;
                rdata_d[irq_prio_pkg::POS_VSEL]  = vsel_q;
                rdata_d[irq_prio_pkg::POS_LEVEL +: 4] = new_level_q;
                rdata_d[irq_prio_pkg::POS_VEC +: 7] =
                    vsel_q ? vec_live_q : vec_last_q; // [R12]
            end
            rdata_d = rdata_d & mask_of(addr_in); // [R03]
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
                level_q[i] <= irq_prio_pkg::LEVEL_RESET; // [R04]
            vsel_q     <= 1'b0;
            unack_q    <= 1'b0;
            new_level_q <= 4'h0;
            vec_last_q <= 7'h00;
            vec_live_q <= 7'h00;
            req_q      <= 1'b0;
            lvl_q      <= 4'h0;
            vec_q      <= 7'h00;
            rdata_q    <= 16'h0000;
        end
        else if (ce_in)
        begin
            for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
                level_q[i] <= level_d[i];
            vsel_q     <= vsel_d;
            unack_q    <= unack_d;
            new_level_q <= new_level_d;
            vec_last_q <= vec_last_d;
            vec_live_q <= vec_live_d;
            req_q      <= req_d;
            lvl_q      <= lvl_d;
            vec_q      <= vec_d;
            rdata_q    <= rdata_d;
        end
    end

    assign rdata_out      = rdata_q;
    assign irq_out        = req_q;
    assign irq_level_out  = lvl_q;
    assign irq_vector_out = vec_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence acked_seq;
        ce_in && ack_in && irq_out;
    endsequence

    chk_zero_code_silent: assert property ( // [R02]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && !trap_req_in && levels_flat == 24'h000000)
        |=> !irq_out)
        else $error("request raised for disabled sources");

    chk_reset_levels: assert property ( // [R04]
        @(posedge clk_in) disable iff (reset_in)
        $fell(reset_in) |-> levels_flat == 24'h924924)
        else $error("priority fields not at level 4 after reset");

    chk_trap_unmasked: assert property ( // [R19]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && trap_req_in) |=> irq_out &&
        irq_level_out == $past(trap_level_in))
        else $error("trap request was masked");

    chk_masked_flag: assert property ( // [R08]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && !trap_req_in && found &&
         {1'b0, best_level} <= cpu_level_in)
        |=> unack_q && !irq_out)
        else $error("masked request not flagged");

    chk_ack_capture: assert property ( // [R10] [R11]
        @(posedge clk_in) disable iff (reset_in)
        acked_seq |=> vec_last_q == $past(irq_vector_out) &&
        new_level_q == $past(irq_level_out))
        else $error("acknowledge not captured");

    chk_live_readback: assert property ( // [R09]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && rd_in && addr_in == irq_prio_pkg::OFS_TEST && vsel_q)
        |=> rdata_out[6:0] == $past(vec_live_q))
        else $error("live vector not shown");

    chk_unimpl_zero: assert property ( // [R03]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && rd_in) |=>
        (rdata_out & ~mask_of($past(addr_in))) == 16'h0000)
        else $error("unimplemented bits read nonzero");

    chk_needs_flag: assert property ( // [R17]
        @(posedge clk_in) disable iff (reset_in)
        (ce_in && !trap_req_in && (flag_in & enable_in) == 8'h00)
        |=> !irq_out)
        else $error("request without flag and enable");

    chk_vector_range: assert property ( // [R12]
        @(posedge clk_in) disable iff (reset_in)
        !trap_req_in |-> vec_live_d <= irq_prio_pkg::VEC_MAX)
        else $error("vector out of range");

endmodule : irq_prio_ctrl
`default_nettype wire

/* core/fix_note_placeholder.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* sim/cpu_core_model.sv */
// cpu core model: acknowledges a raised request after a set delay
// assumes it shares clk_in and reset_in with the controller
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // bench controls
    input  wire logic       auto_ack_in,
    input  wire logic [3:0] delay_in,
    // controller side
    input  wire logic       irq_in,
    output logic            ack_out
);
    logic [3:0] wait_q;
    logic       done_q;

    // one single-cycle acknowledge per arming, delay counted only while the request stands
    always_ff @(posedge clk_in)
    begin
        ack_out <= 1'b0;
        if (reset_in || !auto_ack_in)
        begin
            wait_q <= 4'h0;
            done_q <= 1'b0;
        end
        else if (irq_in && !done_q)
        begin
            if (wait_q == delay_in)
            begin
                ack_out <= 1'b1;
                done_q  <= 1'b1;
            end
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

/* sim/interrupt_priority_and_vector_status_test.sv */
// self-checking bench for the priority and vector status block
// assumes register indices 0..5 and a cpu model answering requests
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_and_vector_status_test;
    logic        clk_in         = 1'b0;
    logic        reset_in       = 1'b1;
    logic        ce_in          = 1'b1;
    logic [2:0]  addr_in        = 3'h0;
    logic [15:0] wdata_in       = 16'h0000;
    logic        wr_in          = 1'b0;
    logic        rd_in          = 1'b0;
    logic [7:0]  flag_in        = 8'h00;
    logic [7:0]  enable_in      = 8'h00;
    logic        trap_req_in    = 1'b0;
    logic [3:0]  trap_level_in  = 4'h0;
    logic [6:0]  trap_vector_in = 7'h00;
    logic [3:0]  cpu_level_in   = 4'h0;
    logic        auto_ack       = 1'b0;
    logic [3:0]  ack_delay      = 4'h3;
    logic        ack_in;
    logic [15:0] rdata_out;
    logic        irq_out;
    logic [3:0]  irq_level_out;
    logic [6:0]  irq_vector_out;
    int          n_mismatch     = 0;
    int          checked        = 0;
    int          cycles         = 0;
    logic [15:0] rst_v [6] = '{16'h4440, 16'h4000, 16'h0044,
                               16'h0004, 16'h0040, 16'h0000};
    logic [15:0] all_v [6] = '{16'h7770, 16'h7000, 16'h0077,
                               16'h0007, 16'h0070, 16'h2000};
    logic [2:0]  s_ofs [8] = '{3'h0, 3'h0, 3'h0, 3'h1,
                               3'h2, 3'h2, 3'h3, 3'h4};
    int          s_pos [8] = '{4, 8, 12, 12, 0, 4, 0, 4};
    logic [6:0]  s_vec [8] = '{irq_prio_pkg::VEC_S3_ERR,
        irq_prio_pkg::VEC_S3_RX, irq_prio_pkg::VEC_S3_TX,
        irq_prio_pkg::VEC_S4_ERR, irq_prio_pkg::VEC_S4_RX,
        irq_prio_pkg::VEC_S4_TX, irq_prio_pkg::VEC_DISP,
        irq_prio_pkg::VEC_DBG};

    irq_prio_ctrl irq_prio_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in),
        .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .flag_in(flag_in), .enable_in(enable_in),
        .trap_req_in(trap_req_in), .trap_level_in(trap_level_in),
        .trap_vector_in(trap_vector_in), .cpu_level_in(cpu_level_in),
        .ack_in(ack_in), .irq_out(irq_out), .irq_level_out(irq_level_out),
        .irq_vector_out(irq_vector_out));

    cpu_core_model cpu_core_model_inst (.clk_in(clk_in), .reset_in(reset_in),
        .auto_ack_in(auto_ack), .delay_in(ack_delay), .irq_in(irq_out),
        .ack_out(ack_in));

    initial
    begin
        forever #10 clk_in = ~clk_in;
    end

    // ----------------------------------------------------------------
    // bus cycles and compares
    // ----------------------------------------------------------------
    task automatic fail(string msg);
        n_mismatch++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk_word(logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp) fail($sformatf("read %h, want %h", got, exp));
    endtask : chk_word

    task automatic chk_irq(logic e_irq, logic [3:0] e_lvl, logic [6:0] e_vec);
        checked++;
        if (irq_out !== e_irq ||
            (e_irq && {irq_level_out, irq_vector_out} !== {e_lvl, e_vec}))
            fail($sformatf("request %b %h %h, want %b %h %h", irq_out,
                 irq_level_out, irq_vector_out, e_irq, e_lvl, e_vec));
    endtask : chk_irq

    task automatic reg_wr(logic [2:0] a, logic [15:0] d);
        @(posedge clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(logic [2:0] a, logic [15:0] exp);
        @(posedge clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        chk_word(rdata_out, exp);
    endtask : rd_chk

    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic clear_levels;
        for (int a = 0; a < 5; a++) reg_wr(3'(a), 16'h0000);
    endtask : clear_levels

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 6; i++)
            rd_chk(3'(i), rst_v[i]);
        chk_irq(1'b0, 4'h0, 7'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_access;
        for (int i = 0; i < 6; i++)
        begin
            reg_wr(3'(i), 16'hffff);
            rd_chk(3'(i), all_v[i]);
        end
        reg_wr(3'h6, 16'hffff);
        rd_chk(3'h6, 16'h0000);
        rd_chk(3'h7, 16'h0000);
        reg_wr(3'h5, 16'h0000);
        @(posedge clk_in);
        ce_in <= 1'b0;
        reg_wr(3'h4, 16'h0000);
        ce_in <= 1'b1;
        rd_chk(3'h4, 16'h0070);
        $display("test access done");
    endtask : t_access

    task automatic t_each;
        logic [2:0] lv;
        clear_levels;
        for (int i = 0; i < 8; i++)
        begin
            lv = 3'(i % 7 + 1);
            reg_wr(s_ofs[i], 16'(lv) << s_pos[i]);
            @(posedge clk_in);
            flag_in   <= 8'h00;
            enable_in <= 8'h01 << i;
            settle;
            chk_irq(1'b0, 4'h0, 7'h00);
            flag_in <= 8'h01 << i;
            settle;
            chk_irq(1'b1, {1'b0, lv}, s_vec[i]);
            enable_in <= 8'h00;
            settle;
            chk_irq(1'b0, 4'h0, 7'h00);
            reg_wr(s_ofs[i], 16'h0000);
            enable_in <= 8'h01 << i;
            settle;
            chk_irq(1'b0, 4'h0, 7'h00);
            flag_in   <= 8'h00;
            enable_in <= 8'h00;
        end
        $display("test each source done");
    endtask : t_each

    task automatic t_levels;
        for (int i = 0; i < 5; i++) reg_wr(3'(i), all_v[i] & 16'h5555);
        flag_in   <= 8'hff;
        enable_in <= 8'hff;
        settle;
        chk_irq(1'b1, 4'h5, irq_prio_pkg::VEC_S3_ERR);
        reg_wr(3'h2, 16'h0065);
        settle;
        chk_irq(1'b1, 4'h6, irq_prio_pkg::VEC_S4_TX);
        cpu_level_in <= 4'h6;
        settle;
        chk_irq(1'b0, 4'h0, 7'h00);
        cpu_level_in   <= 4'hf;
        trap_req_in    <= 1'b1;
        trap_level_in  <= 4'h9;
        trap_vector_in <= 7'h0c;
        settle;
        chk_irq(1'b1, 4'h9, 7'h0c);
        trap_req_in <= 1'b0;
        settle;
        chk_irq(1'b0, 4'h0, 7'h00);
        rd_chk(3'h5, 16'h8000);
        cpu_level_in <= 4'h0;
        flag_in      <= 8'h00;
        enable_in    <= 8'h00;
        settle;
        rd_chk(3'h5, 16'h0000);
        $display("test levels done");
    endtask : t_levels

    task automatic t_ack;
        clear_levels;
        reg_wr(3'h0, 16'h0040);
        flag_in   <= 8'h01;
        enable_in <= 8'h01;
        auto_ack  <= 1'b1;
        for (int n = 0; n < 50 && ack_in !== 1'b1; n++)
        begin
            @(posedge clk_in);
            #1;
        end
        if (ack_in !== 1'b1) fail("no acknowledge seen");
        auto_ack <= 1'b0;
        settle;
        chk_irq(1'b1, 4'h4, irq_prio_pkg::VEC_S3_ERR);
        rd_chk(3'h5, {8'h04, 1'b0, irq_prio_pkg::VEC_S3_ERR});
        flag_in <= 8'h00;
        reg_wr(3'h4, 16'h0020);
        flag_in   <= 8'h80;
        enable_in <= 8'h80;
        settle;
        chk_irq(1'b1, 4'h2, irq_prio_pkg::VEC_DBG);
        rd_chk(3'h5, {8'h04, 1'b0, irq_prio_pkg::VEC_S3_ERR});
        reg_wr(3'h5, 16'h2000);
        rd_chk(3'h5, {8'h24, 1'b0, irq_prio_pkg::VEC_DBG});
        $display("test acknowledge done");
    endtask : t_ack

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset;
        t_access;
        t_each;
        t_levels;
        t_ack;
        wrap_up;
    end
endmodule : interrupt_priority_and_vector_status_test
`default_nettype wire
